// *** dv/pbar_regs_chk.sv ***
// Port checker for the base address register bank
`timescale 1ns/1ps
`default_nettype none
module pbar_regs_chk #(
   parameter int NUM_REGIONS = 5
) (
   // Clock and reset
   input wire logic                     ref_clk,
   input wire logic                     rst,
   // Configuration path
   input wire pbar_pkg::pbar_cfg_req_t  cfgReq,
   input wire logic                     cfgAck,
   input wire logic                     cfgClaim,
   input wire logic [31:0]              cfgRdata,
   // Region status
   input wire logic [NUM_REGIONS-1:0]   regionEnabled,
   input wire logic [NUM_REGIONS-1:0]   regionIsIo
);
   import pbar_pkg::*;
   logic mapped;

   // Offsets that belong to the bank, region five included
   assign mapped = cfgReq.offset inside {8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Handshake and decode of the configuration path
   chk_ack_follows_req: assert property (cfgReq.valid |=> cfgAck)
      else $error("request without answer");
   chk_no_stray_ack: assert property (!cfgReq.valid |=> !cfgAck)
      else $error("answer without request");
   chk_claim_mapped: assert property (cfgReq.valid && mapped |=> cfgClaim)
      else $error("mapped offset not claimed");
   chk_unmapped_quiet: assert property (cfgReq.valid && !mapped |=> !cfgClaim && cfgRdata == 32'h0)
      else $error("unmapped offset answered");
   chk_write_reads_zero: assert property (cfgReq.valid && cfgReq.write |=> cfgRdata == 32'h0)
      else $error("write returned data");
   chk_fifth_reads_zero: assert property (cfgReq.valid && cfgReq.offset == 8'h24 |=> cfgRdata == 32'h0)
      else $error("region five not zero");
   // Read image format
   chk_io_bit_one: assert property (cfgAck && cfgRdata[0] |-> !cfgRdata[1])
      else $error("io bit one set");
   chk_mem_type_high: assert property (cfgAck && !cfgRdata[0] |-> !cfgRdata[2])
      else $error("memory type high bit set");
   // Region zero comes out of reset as an enabled io region
   // Status copies lag the slot setup by one edge, so look one cycle after release
   chk_reset_image: assert property ($fell(rst) |=> regionEnabled == 1 && regionIsIo == 1)
      else $error("reset status wrong");
endmodule

bind pbar_regs_top pbar_regs_chk #(.NUM_REGIONS(NUM_REGIONS)) u_chk (.ref_clk, .rst, .cfgReq, .cfgAck,
   .cfgClaim, .cfgRdata, .regionEnabled, .regionIsIo);
`default_nettype wire

// *** dv/tb_pci_base_address_decode_regs.sv ***
// Self-checking bench for the base address register bank
`timescale 1ns/1ps
`default_nettype none
module tb_pci_base_address_decode_regs;
   import pbar_pkg::*;
   logic             ref_clk;
   logic             rst;
   pbar_cfg_req_t    cfgReq;
   logic             cfgAck;
   logic             cfgClaim;
   logic [31:0]      cfgRdata;
   logic             bootPresent;
   logic             bootValid;
   logic [2:0]       bootIndex;
   logic [31:0]      bootData;
   logic             probeValid;
   logic [31:0]      probeAddr;
   logic             probeIo;
   logic [4:0]       regionHit;
   logic [4:0]       regionEnabled;
   logic [4:0]       regionIsIo;
   logic [9:0]       regionWidth;
   logic [31:0]      rnd;
   int               mismatches;
   int               testsRun;
   pbar_region_cfg_t mCfg [5];
   logic [31:0]      mBase [5];

   pbar_regs_top DUT (.ref_clk, .rst, .cfgReq, .cfgAck, .cfgClaim, .cfgRdata, .bootPresent, .bootValid,
      .bootIndex, .bootData, .probeValid, .probeAddr, .probeIo, .regionHit, .regionEnabled, .regionIsIo,
      .regionWidth);

   // Reference model helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] img(input int i);
      if (!mCfg[i].enabled)
         return 32'h0;
      if (mCfg[i].isIo)
         return (mBase[i] & mCfg[i].mask) | 32'h1;
      return (mBase[i] & mCfg[i].mask) | {28'h0, mCfg[i].prefetch, 1'b0, mCfg[i].belowMeg, 1'b0};
   endfunction
   function automatic pbar_region_cfg_t dec(input int i, input logic [31:0] d);
      pbar_region_cfg_t c;
      c = '0;
      // A zero value leaves the region fully cleared, mask included
      if (d == 32'h0)
         return c;
      c.enabled = 1'b1;
      c.isIo = d[0];
      c.prefetch = !d[0] && d[3] && i != 0;
      c.belowMeg = !d[0] && d[1];
      c.busWidth = (i == 0) ? 2'h0 : d[31:30];
      c.mask = d[0] ? (d | 32'hffffff00) & 32'hfffffffc : (d | 32'he0000000) & 32'hfffffff0;
      return c;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One configuration access, entered at a falling edge; writes follow the byte enables
   task automatic acc(input logic w, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
      int j;
      logic [31:0] m;
      logic [31:0] e;
      j = (off >= 8'h10 && off <= 8'h20 && off[1:0] == 2'h0) ? (off - 8'h10) / 4 : 5;
      e = 32'h0;
      cfgReq = {1'b1, w, off, be, d};
      @(negedge ref_clk);
      // Valid stays up so a following access runs back to back
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (j < 5 && w)
         mBase[j] = (mBase[j] & ~(m & mCfg[j].mask)) | (d & m & mCfg[j].mask);
      if (j < 5 && !w)
         e = img(j);
      chk("ack", 32'h1, {31'h0, cfgAck});
      chk("claim", {31'h0, off inside {8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24}}, {31'h0, cfgClaim});
      chk("rdata", e, cfgRdata);
   endtask

   task automatic boot(input logic p, input logic [2:0] i, input logic [31:0] d);
      cfgReq.valid = 1'b0;
      bootPresent = p;
      bootValid = 1'b1;
      bootIndex = i;
      bootData = d;
      @(negedge ref_clk);
      bootValid = 1'b0;
      if (p && i < 3'h5)
         mCfg[i] = dec(i, d);
   endtask

   // Reset, then sizing of every offset; a boot value lost to reset reads as disabled, or as 64-byte I/O in region zero
   task automatic do_reset();
      rst = 1'b1;
      cfgReq.valid = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 5; i++) begin
         mCfg[i] = (i == 0) ? {4'hc, 2'h0, 32'hffffffc0} : '0;
         mBase[i] = 32'hffffffff;
      end
      acc(1'b0, 8'h10, 4'hf, 32'h0);
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, 8'h10 + 8'(4 * i), 4'hf, 32'hffffffff);
         acc(1'b0, 8'h10 + 8'(4 * i), 4'hf, 32'h0);
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Watchdog so a hang still reaches the report
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end

   // Main sequence: reset, random boot, sizing, write and probe, then a second reset
   initial begin
      logic [31:0] d;
      int j;
      int sh;
      {cfgReq, bootPresent, bootValid, bootIndex, bootData, probeValid, probeAddr, probeIo} = '0;
      rnd = 32'h5b;
      rst = 1'b1;
      @(negedge ref_clk);
      do_reset();
      for (int n = 0; n < 80; n++) begin
         rnd = lfsr(rnd);
         sh = rnd[11] ? 2 + rnd[14:12] % 7 : 4 + rnd[16:12] % 26;
         d = (32'hffffffff << sh) | (rnd[11] ? 32'h1 : {28'h0, rnd[17], 1'b0, rnd[18], 1'b0});
         d[31:30] = rnd[23:22];
         d = (rnd[21:19] == 3'h0) ? 32'h0 : d;
         boot(rnd[6:3] != 4'h0, rnd[2:0], d);
         j = (rnd[2:0] < 3'h5) ? rnd[2:0] : rnd[26:24] % 5;
         acc(1'b1, 8'h10 + 8'(4 * j), 4'hf, 32'hffffffff);
         acc(1'b0, 8'h10 + 8'(4 * j), 4'hf, 32'h0);
         d = lfsr(rnd ^ 32'h3c);
         acc(1'b1, 8'h10 + 8'(4 * j), rnd[30:27], d);
         acc(1'b0, 8'h10 + 8'(4 * j), 4'hf, 32'h0);
         cfgReq.valid = 1'b0;
         probeValid = 1'b1;
         probeIo = mCfg[j].isIo ^ rnd[31];
         probeAddr = mBase[j] & mCfg[j].mask;
         @(negedge ref_clk);
         probeValid = 1'b0;
         chk("hit", {31'h0, mCfg[j].enabled && !rnd[31]}, {31'h0, regionHit[j]});
         for (int r = 0; r < 5; r++)
            chk("status", {mCfg[r].enabled, mCfg[r].isIo, mCfg[r].busWidth},
               {regionEnabled[r], regionIsIo[r], regionWidth[2*r+:2]});
      end
      // Region zero booted into memory space below one megabyte
      boot(1'b1, 3'h0, 32'hffffffc2);
      acc(1'b1, 8'h10, 4'hf, 32'hffffffff);
      cfgReq = {1'b1, 1'b0, 8'h10, 4'hf, 32'h0};
      @(negedge ref_clk);
      chk("region zero memory", 32'hffffffc2, cfgRdata);
      boot(1'b1, 3'h1, 32'hffffff0a);
      do_reset();
      finish_test();
   end
endmodule
`default_nettype wire

// *** pkg/pbar_consts.svh ***
// Offsets, field positions, reset values and limits for the base address register bank
`ifndef PBAR_CONSTS_SVH
`define PBAR_CONSTS_SVH

// Configuration offsets of the six base address registers
`define PBAR_OFF_REGION0    8'h10
`define PBAR_OFF_REGION1    8'h14
`define PBAR_OFF_REGION2    8'h18
`define PBAR_OFF_REGION3    8'h1c
`define PBAR_OFF_REGION4    8'h20
`define PBAR_OFF_REGION5    8'h24

// Field positions
`define PBAR_BIT_SPACE      0
`define PBAR_BIT_BELOW_MEG  1
`define PBAR_BIT_TYPE_HIGH  2
`define PBAR_BIT_PREFETCH   3
`define PBAR_BIT_WIDTH_HI   31
`define PBAR_BIT_WIDTH_LO   30

// Reset values
`define PBAR_REGION0_RESET  32'hffffffc1
`define PBAR_REGION0_MASK   32'hffffffc0
`define PBAR_BASE_RESET     32'hffffffff

// Mask bits always present: largest memory region 512M, largest I/O region 256
`define PBAR_MEM_FORCED     32'he0000000
`define PBAR_IO_FORCED      32'hffffff00
// Smallest regions: 16 bytes memory, 4 bytes I/O
`define PBAR_MEM_LOW_CLEAR  32'hfffffff0
`define PBAR_IO_LOW_CLEAR   32'hfffffffc

`endif

// *** pkg/pbar_pkg.sv ***
// Types shared by the base address register bank
package pbar_pkg;

   // Decoded setup of one region, as loaded from boot memory
   typedef struct packed {
      logic        enabled;
      logic        isIo;
      logic        prefetch;
      logic        belowMeg;
      logic [1:0]  busWidth;
      logic [31:0] mask;
   } pbar_region_cfg_t;

   // One configuration access
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  offset;
      logic [3:0]  byteEn;
      logic [31:0] data;
   } pbar_cfg_req_t;

endpackage

// *** src/pbar_boot_decode.sv ***
// Turns a raw boot value into a region setup
`timescale 1ns/1ps
`default_nettype none
`include "pbar_consts.svh"

module pbar_boot_decode (
   // Boot side
   input  wire logic                      bootPresent,
   input  wire logic                      isRegionZero,
   input  wire logic [31:0]               bootData,
   // Decoded setup
   output pbar_pkg::pbar_region_cfg_t     regionCfg
);
   import pbar_pkg::*;

   logic enabled;
   logic isIo;

   // Zero value or missing memory decodes as disabled; with memory missing the slot never loads it
   assign enabled = bootPresent && (bootData != 32'h00000000);      // [RULE_12]
   assign isIo    = bootData[`PBAR_BIT_SPACE];                       // [RULE_06] [RULE_07]

   // Mask bits enabled one by one; sizes outside the range cannot occur
   always_comb begin
      regionCfg          = '0;
      regionCfg.enabled  = enabled;
      regionCfg.isIo     = isIo;
      if (enabled) begin
         if (isIo) begin
            regionCfg.mask = (bootData | `PBAR_IO_FORCED) & `PBAR_IO_LOW_CLEAR;   // [RULE_09] [RULE_14]
         end else begin
            regionCfg.mask = (bootData | `PBAR_MEM_FORCED) & `PBAR_MEM_LOW_CLEAR; // [RULE_09] [RULE_13]
            // Upper type bit is dropped, so 64-bit and reserved types never appear
            regionCfg.belowMeg = bootData[`PBAR_BIT_BELOW_MEG];      // [RULE_01] [RULE_02] [RULE_03] [RULE_16]
            // Region zero never reports prefetchable
            regionCfg.prefetch = bootData[`PBAR_BIT_PREFETCH] && !isRegionZero; // [RULE_16]
         end
         if (!isRegionZero) begin
            regionCfg.busWidth = bootData[`PBAR_BIT_WIDTH_HI:`PBAR_BIT_WIDTH_LO]; // [RULE_15]
         end
      end
   end

endmodule
`default_nettype wire

// *** src/pbar_region_slot.sv ***
// One implemented base address register: setup, stored base and decode
`timescale 1ns/1ps
`default_nettype none
`include "pbar_consts.svh"

module pbar_region_slot #(
   parameter bit IS_ZERO = 1'b0
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // Boot load
   input  wire logic                      loadEn,
   input  wire pbar_pkg::pbar_region_cfg_t loadCfg,
   // Configuration write
   input  wire logic                      wrEn,
   input  wire logic [3:0]                wrByteEn,
   input  wire logic [31:0]               wrData,
   // Address probe
   input  wire logic [31:0]               probeAddr,
   input  wire logic                      probeIo,
   // Results
   output pbar_pkg::pbar_region_cfg_t     cfg_reg,
   output logic [31:0]                    readWord,
   output logic                           hit
);
   import pbar_pkg::*;

   logic [31:0] base_reg;
   logic [31:0] base_next;

   // Setup: region zero starts as 64-byte I/O, others disabled with attributes cleared
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_reg <= '0;                                               // [RULE_05]
         if (IS_ZERO) begin
            cfg_reg.enabled <= 1'b1;                                  // [RULE_18]
            cfg_reg.isIo    <= 1'b1;
            cfg_reg.mask    <= `PBAR_REGION0_MASK;
         end
      end else if (loadEn) begin
         cfg_reg <= loadCfg;                                          // [RULE_05] [RULE_19]
      end
   end

   // Only mask-enabled bits of lanes being written change
   always_comb begin
      base_next = base_reg;
      for (int b = 0; b < 4; b++) begin
         if (wrByteEn[b]) begin
            base_next[b*8 +: 8] = wrData[b*8 +: 8];
         end
      end
      base_next = (base_next & cfg_reg.mask) | (base_reg & ~cfg_reg.mask); // [RULE_20]
   end

   // Stored base
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         base_reg <= `PBAR_BASE_RESET;
      end else if (wrEn) begin
         base_reg <= base_next;
      end
   end

   // Read image: address bits under mask plus fixed low attribute bits
   always_comb begin
      readWord = 32'h00000000;                                        // [RULE_11]
      if (cfg_reg.enabled) begin
         if (cfg_reg.isIo) begin
            readWord = (base_reg & cfg_reg.mask) | 32'h00000001;      // [RULE_07] [RULE_08] [RULE_10] [RULE_14]
         end else begin
            readWord = base_reg & cfg_reg.mask;                       // [RULE_06] [RULE_13] [RULE_20]
            readWord[`PBAR_BIT_PREFETCH]  = cfg_reg.prefetch;         // [RULE_16]
            readWord[`PBAR_BIT_TYPE_HIGH] = 1'b0;                     // [RULE_02] [RULE_03]
            readWord[`PBAR_BIT_BELOW_MEG] = cfg_reg.belowMeg;         // [RULE_01]
         end
      end
   end

   // Decode against the placed region
   assign hit = cfg_reg.enabled && (cfg_reg.isIo == probeIo) &&
                (((probeAddr ^ base_reg) & cfg_reg.mask) == 32'h00000000); // [RULE_08]

endmodule
`default_nettype wire

// *** src/pbar_regs_top.sv ***
// Base address register bank on the configuration path with boot loading and decode
//
// Function
// RULE_01 - Type 00 anywhere, 01 below one megabyte
// RULE_02 - 64-bit memory type never presented
// RULE_03 - Reserved type 11 never used
// RULE_04 - Boot data leaves upper type bit clear
// RULE_05 - Below-meg bit reset, then boot reloaded
// RULE_06 - Bit zero low means memory space
// RULE_07 - Bit zero high means I/O space
// RULE_08 - I/O bits 31:2 place the region
// RULE_09 - Boot value enables address bits individually
// RULE_10 - I/O bit one reads zero
// RULE_11 - Disabled register reads all zeros
// RULE_12 - Zero boot value or no memory disables; with no boot memory the load is skipped and the region keeps its setup
// RULE_13 - Memory sizing reads 16 bytes to 512M
// RULE_14 - I/O sizing reads 4 to 256, bit0 set
// RULE_15 - Top boot bits select region bus width
// RULE_16 - Boot sets prefetch and type attribute bits
// RULE_17 - Sixth register always reads zero
// RULE_18 - Region zero resets as 64-byte I/O
// RULE_19 - Region zero may boot into memory space
// RULE_20 - Writes touch masked bits; reads add attributes
`timescale 1ns/1ps
`default_nettype none
`include "pbar_consts.svh"

module pbar_regs_top #(
   parameter int NUM_REGIONS = 5
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // Configuration access
   input  wire pbar_pkg::pbar_cfg_req_t   cfgReq,
   output logic                           cfgAck,
   output logic                           cfgClaim,
   output logic [31:0]                    cfgRdata,
   // Boot memory load
   input  wire logic                      bootPresent,
   input  wire logic                      bootValid,
   input  wire logic [2:0]                bootIndex,
   input  wire logic [31:0]               bootData,
   // Address decode
   input  wire logic                      probeValid,
   input  wire logic [31:0]               probeAddr,
   input  wire logic                      probeIo,
   output logic [NUM_REGIONS-1:0]         regionHit,
   // Region status
   output logic [NUM_REGIONS-1:0]         regionEnabled,
   output logic [NUM_REGIONS-1:0]         regionIsIo,
   output logic [2*NUM_REGIONS-1:0]       regionWidth
);
   import pbar_pkg::*;

   pbar_region_cfg_t            bootCfg;
   pbar_region_cfg_t            slotCfg [NUM_REGIONS];
   logic [31:0]                 slotWord [NUM_REGIONS];
   logic [NUM_REGIONS-1:0]      slotHit;
   logic [NUM_REGIONS-1:0]      slotWrite;
   logic [NUM_REGIONS-1:0]      slotLoad;
   logic [2:0]                  accessIndex;
   logic                        accessMapped;
   logic [31:0]                 cfgRdata_next;
   logic                        cfgClaim_next;

   // Shared decoder: boot loads arrive one value at a time
   pbar_boot_decode u_boot_decode (
      .bootPresent  (bootPresent),
      .isRegionZero (bootIndex == 3'h0),
      .bootData     (bootData),
      .regionCfg    (bootCfg)
   );

   // Offset to register index; region five is claimed but holds nothing
   always_comb begin
      accessIndex  = 3'h0;
      accessMapped = 1'b1;
      case (cfgReq.offset)
         `PBAR_OFF_REGION0: accessIndex = 3'h0;
         `PBAR_OFF_REGION1: accessIndex = 3'h1;
         `PBAR_OFF_REGION2: accessIndex = 3'h2;
         `PBAR_OFF_REGION3: accessIndex = 3'h3;
         `PBAR_OFF_REGION4: accessIndex = 3'h4;
         `PBAR_OFF_REGION5: accessIndex = 3'h5;                       // [RULE_17]
         default: begin
            accessMapped = 1'b0;
         end
      endcase
   end

   // One slot per implemented register
   for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_slot
      assign slotWrite[g] = cfgReq.valid && cfgReq.write && accessMapped && (accessIndex == 3'(g)); // [RULE_20]
      // Loads only take place with boot memory present
      assign slotLoad[g]  = bootValid && bootPresent && (bootIndex == 3'(g)); // [RULE_05] [RULE_19]

      pbar_region_slot #(
         .IS_ZERO (g == 0)
      ) u_slot (
         .ref_clk   (ref_clk),
         .rst       (rst),
         .loadEn    (slotLoad[g]),
         .loadCfg   (bootCfg),
         .wrEn      (slotWrite[g]),
         .wrByteEn  (cfgReq.byteEn),
         .wrData    (cfgReq.data),
         .probeAddr (probeAddr),
         .probeIo   (probeIo),
         .cfg_reg   (slotCfg[g]),
         .readWord  (slotWord[g]),
         .hit       (slotHit[g])
      );
   end

   // Read data: unimplemented and unmapped offsets answer zero
   always_comb begin
      cfgRdata_next = 32'h00000000;                                   // [RULE_17]
      cfgClaim_next = cfgReq.valid && accessMapped;
      if (cfgReq.valid && !cfgReq.write && accessMapped) begin
         for (int i = 0; i < NUM_REGIONS; i++) begin
            if (accessIndex == 3'(i)) begin
               cfgRdata_next = slotWord[i];                           // [RULE_11] [RULE_13] [RULE_14]
            end
         end
      end
   end

   // Answer one cycle after the access, back to back allowed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfgAck   <= 1'b0;
         cfgClaim <= 1'b0;
         cfgRdata <= 32'h00000000;
      end else begin
         cfgAck   <= cfgReq.valid;
         cfgClaim <= cfgClaim_next;
         cfgRdata <= cfgRdata_next;
      end
   end

   // Registered decode result, cleared when nothing is probed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regionHit <= '0;
      end else begin
         regionHit <= probeValid ? slotHit : '0;
      end
   end

   // Registered status copies for the pass-through side
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regionEnabled <= '0;
         regionIsIo    <= '0;
         regionWidth   <= '0;
      end else begin
         for (int i = 0; i < NUM_REGIONS; i++) begin
            regionEnabled[i]     <= slotCfg[i].enabled;               // [RULE_12]
            regionIsIo[i]        <= slotCfg[i].isIo;
            regionWidth[2*i +: 2] <= slotCfg[i].busWidth;             // [RULE_15]
         end
      end
   end

endmodule
`default_nettype wire
